/* pkg/pibcfg_pkg.sv */
// constants for the bridge function 0 configuration header
package pibcfg_pkg;
    localparam logic [7:0] OFS_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLASS_REV = 8'h08;
    localparam logic [7:0] OFS_HEADER_MISC = 8'h0C;
    localparam logic [7:0] OFS_SUBSYS_IDS = 8'h2C;
    localparam logic [7:0] OFS_MISC_CONTROL = 8'h44;
    localparam logic [7:0] OFS_SUBSYS_ALIAS = 8'h70;
    localparam logic [2:0] FUNC_BRIDGE = 3'h0;
    // arbitrary identity values, not any real part
    localparam logic [15:0] MAKER_CODE = 16'h1234;
    localparam logic [15:0] PART_CODE = 16'h5678;
    localparam logic [7:0] SILICON_REV = 8'h3C;
    localparam logic [23:0] BRIDGE_CLASS = 24'h060100;
    localparam logic [31:0] CMD_STATUS_RESET = 32'h0200000F;
    localparam logic [31:0] HEADER_MISC_RESET = 32'h00800000;
    localparam logic [31:0] SUBSYS_RESET = 32'h00000000;
    localparam int CMD_SHUTDOWN_BIT = 3;
    localparam int STS_TGT_ABORT_BIT = 28;
    localparam int STS_MST_ABORT_BIT = 29;
    localparam int MISC_PULSE_SEL_BIT = 0;
    localparam int MISC_LOCK_BIT = 1;
    // legacy and relocatable IO windows
    localparam logic [15:0] IDE_PRI_CMD_BASE = 16'h01F0;
    localparam logic [15:0] IDE_SEC_CMD_BASE = 16'h0170;
    localparam logic [15:0] IDE_CMD_SIZE = 16'h0008;
    localparam logic [15:0] IDE_CTL_SIZE = 16'h0004;
    localparam logic [15:0] IDE_BM_SIZE = 16'h0010;
    localparam logic [15:0] SYSMGT_SIZE = 16'h0100;
    localparam logic [15:0] ELCR_BASE = 16'h04D0;
    localparam logic [15:0] ELCR_SIZE = 16'h0002;
    localparam logic [15:0] RESET_PORT = 16'h0CF9;
    // shutdown pulse timing
    localparam int PULSE_NS = 1000;
    localparam int CLK_NS = 50;
    localparam logic [7:0] PULSE_CYCLES = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);
endpackage : pibcfg_pkg

/* rtl/pibcfg_io_decode.sv */
// io window decoder for fixed and relocatable bridge spaces
`timescale 1ns/1ps
module pibcfg_io_decode
    import pibcfg_pkg::*;
(
    // access
    input wire logic [15:0] io_addr,
    input wire logic ide_native,
    // relocatable bases
    input wire logic [15:0] ide_pri_cmd_base,
    input wire logic [15:0] ide_pri_ctl_base,
    input wire logic [15:0] ide_sec_cmd_base,
    input wire logic [15:0] ide_sec_ctl_base,
    input wire logic [15:0] ide_bm_base,
    input wire logic [15:0] sysmgt_base,
    // hits
    output logic hit_ide,
    output logic hit_sysmgt,
    output logic hit_elcr,
    output logic hit_reset_port
);
    // sizes are powers of two, so the base is masked to the window
    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic [15:0] sz);
        logic [15:0] m;
        m = ~(sz - 16'h0001);
        return (a & m) == (b & m);
    endfunction : in_win

    logic legacy_ide;
    logic native_ide;

    always_comb
    begin
        legacy_ide = in_win(io_addr, IDE_PRI_CMD_BASE, IDE_CMD_SIZE)
                   | in_win(io_addr, IDE_SEC_CMD_BASE, IDE_CMD_SIZE);
        native_ide = in_win(io_addr, ide_pri_cmd_base, IDE_CMD_SIZE)
                   | in_win(io_addr, ide_pri_ctl_base, IDE_CTL_SIZE)
                   | in_win(io_addr, ide_sec_cmd_base, IDE_CMD_SIZE)
                   | in_win(io_addr, ide_sec_ctl_base, IDE_CTL_SIZE)
                   | in_win(io_addr, ide_bm_base, IDE_BM_SIZE);
        hit_ide = ide_native ? native_ide : legacy_ide;
        hit_sysmgt = in_win(io_addr, sysmgt_base, SYSMGT_SIZE);
        hit_elcr = in_win(io_addr, ELCR_BASE, ELCR_SIZE);
        hit_reset_port = (io_addr == RESET_PORT);
    end
endmodule : pibcfg_io_decode

/* rtl/pibcfg_top.sv */
// bridge function 0 configuration header with shutdown and io decode
`timescale 1ns/1ps
module pibcfg_top
    import pibcfg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // configuration access, type 0, function in addr 10:8
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [10:2] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // bus master outcome events
    input wire logic target_abort_event,
    input wire logic master_abort_event,
    // special cycle
    input wire logic shutdown_cycle,
    output logic processor_restart_n,
    output logic processor_init_n,
    // io decode
    input wire logic [15:0] io_addr,
    input wire logic ide_native,
    input wire logic [15:0] ide_pri_cmd_base,
    input wire logic [15:0] ide_pri_ctl_base,
    input wire logic [15:0] ide_sec_cmd_base,
    input wire logic [15:0] ide_sec_ctl_base,
    input wire logic [15:0] ide_bm_base,
    input wire logic [15:0] sysmgt_base,
    output logic hit_ide,
    output logic hit_sysmgt,
    output logic hit_elcr,
    output logic hit_reset_port
);
    typedef enum logic [1:0] {
        PIB_IDLE = 2'b00,
        PIB_PULSE = 2'b01
    } pib_state_e;

    // merge write data into the bytes enabled
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // dword offset as a byte address, shared by strobes and read mux
    function automatic logic [7:0] cfg_offset(input logic [10:2] a);
        return {a[7:2], 2'b00};
    endfunction : cfg_offset

    // hardware set beats a software clear landing in the same cycle
    function automatic logic w1c_next(input logic flag,
                                      input logic set,
                                      input logic clr);
        return set | (flag & ~clr);
    endfunction : w1c_next

    logic [31:0] be_mask;
    logic [31:0] wmask;
    logic sel_bridge;
    logic wr_cmd;
    logic wr_misc;
    logic wr_alias;
    logic shutdown_en_q;
    logic tgt_abort_q;
    logic mst_abort_q;
    logic pulse_sel_q;
    logic lock_q;
    logic [31:0] subsys_q;
    logic subsys_locked_q;
    logic [31:0] cmd_status;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic ack_q;
    pib_state_e state_q;
    logic [7:0] pulse_cnt_q;
    logic start_pulse;
    logic end_pulse;
    logic restart_n_q;
    logic init_n_q;
    logic [31:0] misc_rd;
    logic [15:0] subsystem_code;
    logic [15:0] subsystem_maker_code;

    // only type 0 accesses to function 0 are claimed
    assign sel_bridge = cfg_req && (cfg_addr[10:8] == FUNC_BRIDGE);
    assign be_mask = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                      {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
    assign wmask = cfg_wdata & be_mask;
    assign wr_cmd = sel_bridge && cfg_write
                 && (cfg_offset(cfg_addr) == OFS_CMD_STATUS);
    assign wr_misc = sel_bridge && cfg_write
                  && (cfg_offset(cfg_addr) == OFS_MISC_CONTROL);
    assign wr_alias = sel_bridge && cfg_write
                   && (cfg_offset(cfg_addr) == OFS_SUBSYS_ALIAS);
    // upper half subsystem code, lower half its maker
    assign subsystem_code = subsys_q[31:16];
    assign subsystem_maker_code = subsys_q[15:0];
    // a cycle arriving mid-pulse never restarts the count
    assign start_pulse = (state_q == PIB_IDLE) && shutdown_cycle
                      && shutdown_en_q;
    assign end_pulse = (state_q == PIB_PULSE) && (pulse_cnt_q == 8'h01);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            shutdown_en_q <= CMD_STATUS_RESET[CMD_SHUTDOWN_BIT];
        end
        else if (wr_cmd && cfg_byte_en[0])
        begin
            shutdown_en_q <= cfg_wdata[CMD_SHUTDOWN_BIT];
        end
    end

    // a new abort wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tgt_abort_q <= 1'b0;
            mst_abort_q <= 1'b0;
        end
        else
        begin
            tgt_abort_q <= w1c_next(tgt_abort_q, target_abort_event,
                wr_cmd & wmask[STS_TGT_ABORT_BIT]);
            mst_abort_q <= w1c_next(mst_abort_q, master_abort_event,
                wr_cmd & wmask[STS_MST_ABORT_BIT]);
        end
    end

    // misc control: pulse select read-write, lock bit write-one-only
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pulse_sel_q <= 1'b0;
            lock_q <= 1'b0;
        end
        else if (wr_misc && cfg_byte_en[0])
        begin
            pulse_sel_q <= cfg_wdata[MISC_PULSE_SEL_BIT];
            lock_q <= lock_q | cfg_wdata[MISC_LOCK_BIT];
        end
    end

    // alias accepts one write after reset, then the ids freeze
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            subsys_q <= SUBSYS_RESET;
            subsys_locked_q <= 1'b0;
        end
        else if (wr_alias && !subsys_locked_q)
        begin
            subsys_q <= merge_bytes(subsys_q, cfg_wdata, cfg_byte_en);
            subsys_locked_q <= 1'b1;
        end
    end

    // fixed bits come straight from the reset word, live bits patched in
    always_comb
    begin
        cmd_status = CMD_STATUS_RESET;
        cmd_status[CMD_SHUTDOWN_BIT] = shutdown_en_q;
        cmd_status[STS_TGT_ABORT_BIT] = tgt_abort_q;
        cmd_status[STS_MST_ABORT_BIT] = mst_abort_q;
        misc_rd = 32'h00000000;
        misc_rd[MISC_PULSE_SEL_BIT] = pulse_sel_q;
        misc_rd[MISC_LOCK_BIT] = lock_q;
    end

    always_comb
    begin
        rdata_d = 32'h00000000;
        case (cfg_offset(cfg_addr))
            OFS_IDENTITY: rdata_d = {PART_CODE, MAKER_CODE};
            OFS_CMD_STATUS: rdata_d = cmd_status;
            OFS_CLASS_REV: rdata_d = {BRIDGE_CLASS, SILICON_REV};
            OFS_HEADER_MISC: rdata_d = HEADER_MISC_RESET;
            OFS_SUBSYS_IDS:
                rdata_d = {subsystem_code, subsystem_maker_code};
            OFS_MISC_CONTROL: rdata_d = misc_rd;
            OFS_SUBSYS_ALIAS: rdata_d = {subsystem_code, subsystem_maker_code};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // answer one cycle after the request; other functions stay silent
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= sel_bridge;
            if (sel_bridge && !cfg_write)
            begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;

    // shutdown pulse; cycles arriving mid-pulse are dropped
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= PIB_IDLE;
            pulse_cnt_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                PIB_IDLE:
                begin
                    if (start_pulse)
                    begin
                        state_q <= PIB_PULSE;
                        pulse_cnt_q <= PULSE_CYCLES;
                    end
                end
                PIB_PULSE:
                begin
                    if (pulse_cnt_q == 8'h01)
                    begin
                        state_q <= PIB_IDLE;
                    end
                    pulse_cnt_q <= pulse_cnt_q - 8'h01;
                end
                default: state_q <= PIB_IDLE;
            endcase
        end
    end

    // pins come from flip-flops so they cannot glitch between states
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            restart_n_q <= 1'b1;
            init_n_q <= 1'b1;
        end
        else if (start_pulse)
        begin
            restart_n_q <= !pulse_sel_q;
            init_n_q <= pulse_sel_q;
        end
        else if (end_pulse)
        begin
            restart_n_q <= 1'b1;
            init_n_q <= 1'b1;
        end
    end

    assign processor_restart_n = restart_n_q;
    assign processor_init_n = init_n_q;

    pibcfg_io_decode u_decode (
        .io_addr(io_addr),
        .ide_native(ide_native),
        .ide_pri_cmd_base(ide_pri_cmd_base),
        .ide_pri_ctl_base(ide_pri_ctl_base),
        .ide_sec_cmd_base(ide_sec_cmd_base),
        .ide_sec_ctl_base(ide_sec_ctl_base),
        .ide_bm_base(ide_bm_base),
        .sysmgt_base(sysmgt_base),
        .hit_ide(hit_ide),
        .hit_sysmgt(hit_sysmgt),
        .hit_elcr(hit_elcr),
        .hit_reset_port(hit_reset_port)
    );
endmodule : pibcfg_top

/* test/pibcfg_assertions.sv */
// checker for the bridge configuration header ports
`timescale 1ns/1ps
module pibcfg_checker
    import pibcfg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [10:2] cfg_addr,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // shutdown
    input wire logic shutdown_cycle,
    input wire logic processor_restart_n,
    input wire logic processor_init_n,
    // io decode
    input wire logic [15:0] io_addr,
    input wire logic ide_native,
    input wire logic [15:0] sysmgt_base,
    input wire logic hit_ide,
    input wire logic hit_sysmgt,
    input wire logic hit_elcr,
    input wire logic hit_reset_port
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic rd;
    logic [16:0] rel;
    assign rd = cfg_req && !cfg_write;
    // 17 bits so an address below the base never wraps into the window
    assign rel = {1'b0, io_addr} - {1'b0, sysmgt_base};
    a_ack_func0: assert property (
        (cfg_req && cfg_addr[10:8] == 3'h0) |=> cfg_ack) else $error("no ack");
    a_ack_only_func0: assert property (
        !(cfg_req && cfg_addr[10:8] == 3'h0) |=> !cfg_ack) else $error("ack");
    a_cmd_enables: assert property (
        rd && cfg_addr == 9'h001 |=> cfg_rdata[2:0] == 3'h7)
        else $error("enables not set");
    a_cmd_fixed: assert property (
        rd && cfg_addr == 9'h001 |=> (cfg_rdata & 32'hCFFFFFF0) ==
        (CMD_STATUS_RESET & 32'hCFFFFFF0)) else $error("cmd fixed bits");
    a_ident_const: assert property (
        rd && cfg_addr == 9'h000 |=> cfg_rdata == {PART_CODE, MAKER_CODE})
        else $error("identity");
    a_class_const: assert property (
        rd && cfg_addr == 9'h002 |=> cfg_rdata == {BRIDGE_CLASS, SILICON_REV})
        else $error("class rev");
    a_header_const: assert property (
        rd && cfg_addr == 9'h003 |=> cfg_rdata == HEADER_MISC_RESET)
        else $error("header misc");
    a_legacy_ide: assert property (
        !ide_native && (io_addr[15:3] == 13'h003E || io_addr[15:3] == 13'h002E)
        |-> hit_ide) else $error("legacy ide miss");
    a_fixed_ports: assert property (
        hit_elcr == (io_addr[15:1] == 15'h0268) &&
        hit_reset_port == (io_addr == 16'h0CF9)) else $error("fixed ports");
    a_sysmgt_win: assert property (
        hit_sysmgt == (rel < 17'h00100)) else $error("sysmgt window");
    a_pulse_cause: assert property (
        $fell(processor_restart_n) || $fell(processor_init_n) |->
        $past(shutdown_cycle)) else $error("pulse without cycle");
    a_pulse_width: assert property (
        $fell(processor_init_n) |-> !processor_init_n [*8] ##12
        !processor_init_n ##1 $rose(processor_init_n))
        else $error("init pulse width");
    a_restart_width: assert property (
        $fell(processor_restart_n) |-> !processor_restart_n [*8] ##12
        !processor_restart_n ##1 $rose(processor_restart_n))
        else $error("restart pulse width");
    a_one_output: assert property (
        processor_restart_n || processor_init_n) else $error("both low");
    c_ack: cover property (cfg_ack);
    c_restart: cover property ($fell(processor_restart_n));
    c_init: cover property ($fell(processor_init_n));
endmodule : pibcfg_checker

bind pibcfg_top pibcfg_checker u_pibcfg_checker (.*);

/* test/pibcfg_host.sv */
// host model issuing type 0 configuration cycles
`timescale 1ns/1ps
module pibcfg_host
(
    // clock
    input wire logic clk_sys,
    // request
    output logic cfg_req = 1'b0,
    output logic cfg_write = 1'b0,
    output logic [10:2] cfg_addr = 9'h000,
    output logic [3:0] cfg_byte_en = 4'h0,
    output logic [31:0] cfg_wdata = 32'h0,
    // answer
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    // one-cycle request, function in 10:8, dword offset in 7:2
    task automatic xfer(input logic w, input logic [2:0] fn,
        input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] rd, output logic ack);
        ack = 1'b0;
        rd = 32'h0;
        @(posedge clk_sys);
        #2;
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_addr = {fn, ofs[7:2]};
        cfg_byte_en = be;
        cfg_wdata = wd;
        @(posedge clk_sys);
        #2;
        cfg_req = 1'b0;
        // released lines carry no stale value
        cfg_byte_en = ~be;
        cfg_wdata = ~wd;
        // the answer stands for the whole cycle after the request edge
        ack = cfg_ack;
        rd = cfg_rdata;
    endtask : xfer
endmodule : pibcfg_host

/* test/tb.sv */
// self-checking bench for the bridge configuration header
`timescale 1ns/1ps
module tb;
    import pibcfg_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cfg_req, cfg_write, cfg_ack, ack, lo;
    logic [10:2] cfg_addr;
    logic [3:0] cfg_byte_en, be;
    logic [31:0] cfg_wdata, cfg_rdata, rd, v, cmd;
    logic target_abort_event = 1'b0;
    logic master_abort_event = 1'b0;
    logic shutdown_cycle = 1'b0;
    logic processor_restart_n, processor_init_n;
    logic [15:0] io_addr = 16'h0;
    logic ide_native = 1'b0;
    logic [15:0] bs [6] = '{default: 16'h0};
    logic hit_ide, hit_sysmgt, hit_elcr, hit_reset_port;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    pibcfg_host u_pibcfg_host (.clk_sys(clk_sys), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
    pibcfg_top u_pibcfg_top (.clk_sys(clk_sys), .resetn(resetn),
        .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .target_abort_event(target_abort_event),
        .master_abort_event(master_abort_event),
        .shutdown_cycle(shutdown_cycle),
        .processor_restart_n(processor_restart_n),
        .processor_init_n(processor_init_n), .io_addr(io_addr),
        .ide_native(ide_native), .ide_pri_cmd_base(bs[0]),
        .ide_pri_ctl_base(bs[1]), .ide_sec_cmd_base(bs[2]),
        .ide_sec_ctl_base(bs[3]), .ide_bm_base(bs[4]), .sysmgt_base(bs[5]),
        .hit_ide(hit_ide), .hit_sysmgt(hit_sysmgt), .hit_elcr(hit_elcr),
        .hit_reset_port(hit_reset_port));
    always #25 clk_sys = ~clk_sys;
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // the run is about 600 cycles, so this only trips on a hang
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] o, logic [3:0] b, logic [31:0] d);
        u_pibcfg_host.xfer(1'b1, FUNC_BRIDGE, o, b, d, rd, ack);
        chk("wr_ack", 32'(ack), 32'h1);
    endtask : wr
    task automatic rdc(string nm, logic [7:0] o, logic [31:0] e,
        logic [31:0] m = 32'hFFFFFFFF);
        u_pibcfg_host.xfer(1'b0, FUNC_BRIDGE, o, 4'hF, 32'h0, rd, ack);
        chk("rd_ack", 32'(ack), 32'h1);
        chk(nm, rd & m, e & m);
    endtask : rdc
    function automatic logic [31:0] ro_val(logic [7:0] o);
        case (o)
            OFS_IDENTITY: return {PART_CODE, MAKER_CODE};
            OFS_CLASS_REV: return {BRIDGE_CLASS, SILICON_REV};
            OFS_HEADER_MISC: return HEADER_MISC_RESET;
            default: return SUBSYS_RESET;
        endcase
    endfunction : ro_val
    function automatic logic win(logic [15:0] b, logic [15:0] s);
        return {1'b0, io_addr} >= {1'b0, b} && {1'b0, io_addr} < b + 17'(s);
    endfunction : win
    function automatic logic exp_ide();
        if (!ide_native)
            return win(IDE_PRI_CMD_BASE, 8) || win(IDE_SEC_CMD_BASE, 8);
        return win(bs[0], 8) || win(bs[1], 4) || win(bs[2], 8) ||
            win(bs[3], 4) || win(bs[4], 16);
    endfunction : exp_ide
    initial
    begin
        logic [7:0] ros [4] = '{8'h00, 8'h08, 8'h0C, 8'h2C};
        v = $urandom(64);
        cmd = CMD_STATUS_RESET;
        repeat (2) @(posedge clk_sys);
        #2;
        resetn = 1'b1;
        rdc("cmd_reset", OFS_CMD_STATUS, cmd);
        foreach (ros[i])
        begin
            rdc("ro", ros[i], ro_val(ros[i]));
            wr(ros[i], 4'hF, 32'hFFFFFFFF);
            rdc("ro_wr", ros[i], ro_val(ros[i]));
        end
        repeat (10)
        begin
            v = $urandom;
            be = 4'($urandom);
            wr(OFS_CMD_STATUS, be, v);
            cmd[3] = be[0] ? v[3] : cmd[3];
            rdc("cmd_wr", OFS_CMD_STATUS, cmd);
        end
        u_pibcfg_host.xfer(1'b0, 3'h1, 8'h00, 4'hF, 32'h0, rd, ack);
        chk("other_func_ack", 32'(ack), 32'h0);
        for (int b = 0; b < 2; b++)
        begin
            @(posedge clk_sys);
            #2;
            {master_abort_event, target_abort_event} = 2'(1 << b);
            @(posedge clk_sys);
            #2;
            {master_abort_event, target_abort_event} = 2'b00;
            cmd[28 + b] = 1'b1;
            rdc("abort_set", OFS_CMD_STATUS, cmd);
            wr(OFS_CMD_STATUS, 4'h8, 32'h0);
            rdc("abort_keep", OFS_CMD_STATUS, cmd);
            wr(OFS_CMD_STATUS, 4'h8, 32'h1 << (28 + b));
            cmd[28 + b] = 1'b0;
            rdc("abort_clr", OFS_CMD_STATUS, cmd);
        end
        wr(OFS_MISC_CONTROL, 4'h1, 32'h2);
        wr(OFS_MISC_CONTROL, 4'h1, 32'h0);
        rdc("lock", OFS_MISC_CONTROL, 32'h2, 32'h2);
        v = $urandom;
        wr(OFS_SUBSYS_ALIAS, 4'hF, v);
        rdc("alias", OFS_SUBSYS_IDS, v);
        wr(OFS_SUBSYS_ALIAS, 4'hF, ~v);
        rdc("alias_once", OFS_SUBSYS_IDS, v);
        resetn = 1'b0;
        @(posedge clk_sys);
        #2;
        resetn = 1'b1;
        rdc("lock_rst", OFS_MISC_CONTROL, 32'h0, 32'h2);
        for (int s = 0; s < 3; s++)
        begin
            wr(OFS_MISC_CONTROL, 4'h1, 32'(s == 1));
            wr(OFS_CMD_STATUS, 4'h1, {28'h0, s < 2, 3'h7});
            @(posedge clk_sys);
            #2;
            shutdown_cycle = 1'b1;
            @(posedge clk_sys);
            #2;
            shutdown_cycle = 1'b0;
            for (int k = 1; k <= 22; k++)
            begin
                lo = s < 2 && k <= 20;
                chk("restart", 32'(processor_restart_n), 32'(!(lo && s == 1)));
                chk("init", 32'(processor_init_n), 32'(!(lo && s == 0)));
                @(posedge clk_sys);
                #2;
            end
        end
        repeat (400)
        begin
            @(posedge clk_sys);
            #2;
            foreach (bs[i]) bs[i] = 16'($urandom) & 16'h3FF0;
            // a 256-byte window base is aligned to its size
            bs[5] = bs[5] & 16'h3F00;
            ide_native = 1'($urandom);
            case ($urandom % 6)
                0: io_addr = 16'h01EC;
                1: io_addr = 16'h016C;
                2: io_addr = 16'h04CE;
                3: io_addr = 16'h0CF6;
                4: io_addr = bs[5] + 16'h00F8;
                default: io_addr = bs[$urandom % 5] - 16'h0002;
            endcase
            io_addr = io_addr + 16'($urandom % 20);
            #1;
            chk("hit_ide", 32'(hit_ide), 32'(exp_ide()));
            chk("hit_sysmgt", 32'(hit_sysmgt), 32'(win(bs[5], 256)));
            chk("hit_elcr", 32'(hit_elcr), 32'(win(ELCR_BASE, 2)));
            chk("hit_rst", 32'(hit_reset_port), 32'(io_addr == 16'h0CF9));
        end
        give_verdict();
    end
endmodule : tb
